// File: rtl/smbus_pkg.sv
package smbus_pkg;
	// address of this part; bit 0 comes from the select pin
	localparam logic [6:0] SLAVE_ADDR_BASE = 7'h3A;
	localparam int CORE_CLK_HZ = 40000000;
	// bus rate limit is core clock / 20
	localparam int BIT_RATE_DIV = 20;
	localparam int HALF_BIT_CYCLES = BIT_RATE_DIV / 2;
	// scl low timeout
	localparam int SCL_LOW_TIMEOUT_MS = 25;
	localparam int SCL_LOW_TIMEOUT_CYCLES = CORE_CLK_HZ / 1000 * SCL_LOW_TIMEOUT_MS;
	// bus free after this many core clocks high
	localparam int BUS_FREE_CYCLES = 1250;
	localparam logic RW_READ = 1'b1;
	localparam logic RW_WRITE = 1'b0;
	typedef enum logic [2:0] {
		SL_IDLE,
		SL_ADDR,
		SL_ADDR_ACK,
		SL_RX,
		SL_RX_ACK,
		SL_TX,
		SL_TX_ACK,
		SL_IGNORE
	} slave_state_t;
	typedef enum logic [3:0] {
		MS_IDLE,
		MS_START,
		MS_BIT_LOW,
		MS_BIT_HIGH,
		MS_ACK_LOW,
		MS_ACK_HIGH,
		MS_STOP_LOW,
		MS_STOP_HIGH,
		MS_STOP_END
	} master_state_t;
endpackage

// File: rtl/smbus_if.sv
`timescale 1ns/1ps
`default_nettype none
interface smbus_if;
	logic dev_scl_oe;
	logic dev_sda_oe;
	logic host_scl_oe;
	logic host_sda_oe;
	wire logic scl;
	wire logic sda;
	// open drain: any enable pulls low, else pulled up
	assign scl = ~(dev_scl_oe | host_scl_oe);
	assign sda = ~(dev_sda_oe | host_sda_oe);
	modport device (input scl, input sda, output dev_scl_oe, output dev_sda_oe);
	modport host (input scl, input sda, output host_scl_oe, output host_sda_oe);
endinterface
`default_nettype wire

// File: rtl/smbus_slave_port.sv
// Operation
// [RULE_01] device is slave only, never master
// [RULE_02] master starts, clocks and stops transfers
// [RULE_03] first byte: address bits 7-1, direction bit 0
// [RULE_04] direction one reads, zero writes
// [RULE_05] receiver acks low; high means nack
// [RULE_06] write: slave acks every received byte
// [RULE_07] read: slave sends, waits master ack
// [RULE_08] sender drives data bits, receiver drives ack
// [RULE_09] slave may stretch scl low
// [RULE_10] user side sees whole bytes only
// [RULE_11] bit rate up to core clock/20
// [RULE_12] lines only pulled low or released
// [RULE_13] address lsb from select pin
// [RULE_14] scl low too long resets state
// [RULE_15] long bus idle resets when enabled
// [RULE_16] start and stop from synchronised lines
// [RULE_17] unmatched address keeps sda released
`timescale 1ns/1ps
`default_nettype none
module smbus_slave_port
	import smbus_pkg::*;
(
	input wire logic i_core_clk, // core clock
	input wire logic i_rst_b, // async reset, low
	smbus_if.device bus, // two-wire bus
	input wire logic i_slave_address_select_pin, // address lsb
	input wire logic i_free_timeout_en, // enable bus free timeout
	input wire logic i_scl_low_timeout_en, // enable scl low timeout
	input wire logic [7:0] i_tx_data, // byte for next read
	input wire logic i_tx_valid, // tx byte ready, else stretch
	output logic o_tx_taken, // pulse: tx byte loaded
	output logic [7:0] o_rx_data, // received byte
	output logic o_rx_valid, // pulse: byte received
	output logic o_busy, // transfer in progress
	output logic o_timeout // pulse: scl low timeout
);
	parameter int SCL_LOW_LIMIT = SCL_LOW_TIMEOUT_CYCLES;

	////////////////////////////////////////////////////////////////
	logic [1:0] scl_sync_reg;
	logic [1:0] sda_sync_reg;
	logic scl_d_reg;
	logic sda_d_reg;
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			scl_sync_reg <= 2'h3;
			sda_sync_reg <= 2'h3;
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end else begin
			scl_sync_reg <= {scl_sync_reg[0], bus.scl};
			sda_sync_reg <= {sda_sync_reg[0], bus.sda};
			scl_d_reg <= scl_sync_reg[1];
			sda_d_reg <= sda_sync_reg[1];
		end
	end
	wire logic scl_s = scl_sync_reg[1];
	wire logic sda_s = sda_sync_reg[1];
	wire logic scl_rise = scl_s & ~scl_d_reg;
	wire logic scl_fall = ~scl_s & scl_d_reg;
	wire logic start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s; // RULE_16
	wire logic stop_det = scl_s & scl_d_reg & ~sda_d_reg & sda_s; // RULE_16

	////////////////////////////////////////////////////////////////
	// timeouts; free counter saturates; scl low counter clears at its limit, or wraps when disabled
	logic [20:0] low_cnt_reg;
	logic [10:0] high_cnt_reg;
	wire logic low_expired = i_scl_low_timeout_en && (low_cnt_reg == 21'(SCL_LOW_LIMIT)); // RULE_14
	wire logic free_expired = i_free_timeout_en && (high_cnt_reg == 11'(BUS_FREE_CYCLES)); // RULE_15
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			low_cnt_reg <= 21'h000000;
			high_cnt_reg <= 11'h000;
		end else begin
			if (scl_s || low_expired)
				low_cnt_reg <= 21'h000000;
			else
				low_cnt_reg <= low_cnt_reg + 21'h000001;
			if (!(scl_s && sda_s))
				high_cnt_reg <= 11'h000;
			else if (high_cnt_reg != 11'(BUS_FREE_CYCLES))
				high_cnt_reg <= high_cnt_reg + 11'h001;
		end
	end

	////////////////////////////////////////////////////////////////
	slave_state_t state_reg, state_next;
	logic [7:0] shift_reg, shift_next;
	logic [2:0] bit_reg, bit_next;
	// set by the eighth rise; a bare bit count of zero cannot tell the fall after start from the fall after a byte
	logic full_reg, full_next;
	logic sda_oe_reg, sda_oe_next;
	logic scl_oe_reg, scl_oe_next;
	logic busy_next;
	logic rx_valid_next;
	logic tx_taken_next;
	logic [7:0] rx_data_next;
	wire logic [6:0] own_addr = {SLAVE_ADDR_BASE[6:1], i_slave_address_select_pin}; // RULE_13
	wire logic addr_match = (shift_reg[7:1] == own_addr); // RULE_03
	wire logic abort = low_expired || free_expired || stop_det;

	// sda changes only while scl is low, so data stays legal; RULE_08
	always_comb begin
		state_next = state_reg;
		shift_next = shift_reg;
		bit_next = bit_reg;
		full_next = full_reg;
		sda_oe_next = sda_oe_reg;
		scl_oe_next = 1'b0;
		busy_next = o_busy;
		rx_valid_next = 1'b0;
		tx_taken_next = 1'b0;
		rx_data_next = o_rx_data;
		if (start_det) begin
			state_next = SL_ADDR;
			bit_next = 3'h0;
			full_next = 1'b0;
			sda_oe_next = 1'b0;
			busy_next = 1'b1;
		end else if (abort) begin
			state_next = SL_IDLE; // RULE_14
			sda_oe_next = 1'b0;
			busy_next = 1'b0;
		end else begin
			case (state_reg)
			SL_ADDR, SL_RX: begin
				if (scl_rise) begin
					shift_next = {shift_reg[6:0], sda_s};
					bit_next = bit_reg + 3'h1;
					full_next = (bit_reg == 3'h7);
				end
			end
			default: begin
			end
			endcase
			case (state_reg)
			SL_ADDR: begin
				if (scl_fall && full_reg) begin
					full_next = 1'b0;
					if (addr_match) begin
						state_next = SL_ADDR_ACK;
						sda_oe_next = 1'b1; // RULE_05
					end else begin
						state_next = SL_IGNORE; // RULE_17
					end
				end
			end
			SL_ADDR_ACK: begin
				if (scl_fall) begin
					if (shift_reg[0] == RW_READ) begin // RULE_04
						state_next = SL_TX;
						scl_oe_next = 1'b1;
						sda_oe_next = 1'b0;
					end else begin
						state_next = SL_RX;
						sda_oe_next = 1'b0;
					end
					bit_next = 3'h0;
				end
			end
			SL_RX: begin
				if (scl_fall && full_reg) begin
					full_next = 1'b0;
					state_next = SL_RX_ACK;
					sda_oe_next = 1'b1; // RULE_06
					rx_data_next = shift_reg; // RULE_10
					rx_valid_next = 1'b1;
				end
			end
			SL_RX_ACK: begin
				if (scl_fall) begin
					state_next = SL_RX;
					sda_oe_next = 1'b0;
				end
			end
			SL_TX: begin
				if (bit_reg == 3'h0 && !scl_s && scl_oe_reg) begin
					// hold scl low until user offers a byte; RULE_09
					if (i_tx_valid) begin
						shift_next = {i_tx_data[6:0], 1'b1};
						sda_oe_next = ~i_tx_data[7];
						tx_taken_next = 1'b1;
						bit_next = 3'h1;
						// hold scl one more clock so sda is set up before it can rise
						scl_oe_next = 1'b1;
					end else begin
						scl_oe_next = 1'b1;
					end
				end else if (scl_fall) begin
					if (bit_reg == 3'h0) begin
						state_next = SL_TX_ACK;
						sda_oe_next = 1'b0;
					end else begin
						sda_oe_next = ~shift_reg[7];
						shift_next = {shift_reg[6:0], 1'b1};
						bit_next = bit_reg + 3'h1;
					end
				end
			end
			SL_TX_ACK: begin
				if (scl_rise) begin
					// nack ends sending; master then stops; RULE_07
					state_next = sda_s ? SL_IGNORE : SL_TX_ACK;
					bit_next = 3'h0;
				end else if (scl_fall) begin
					state_next = SL_TX;
					scl_oe_next = 1'b1;
				end
			end
			default: begin
				sda_oe_next = 1'b0; // RULE_17
			end
			endcase
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state_reg <= SL_IDLE;
			shift_reg <= 8'h00;
			bit_reg <= 3'h0;
			full_reg <= 1'b0;
			sda_oe_reg <= 1'b0;
			scl_oe_reg <= 1'b0;
			o_busy <= 1'b0;
			o_rx_valid <= 1'b0;
			o_rx_data <= 8'h00;
			o_tx_taken <= 1'b0;
			o_timeout <= 1'b0;
		end else begin
			state_reg <= state_next;
			shift_reg <= shift_next;
			bit_reg <= bit_next;
			full_reg <= full_next;
			sda_oe_reg <= sda_oe_next;
			scl_oe_reg <= scl_oe_next;
			o_busy <= busy_next;
			o_rx_valid <= rx_valid_next;
			o_rx_data <= rx_data_next;
			o_tx_taken <= tx_taken_next;
			o_timeout <= low_expired;
		end
	end
	// only pull low, never drive high; never a start or stop; RULE_12 RULE_01
	assign bus.dev_sda_oe = sda_oe_reg;
	assign bus.dev_scl_oe = scl_oe_reg;
endmodule
`default_nettype wire

// File: rtl/smbus_host_master.sv
`timescale 1ns/1ps
`default_nettype none
module smbus_host_master
	import smbus_pkg::*;
(
	input wire logic i_core_clk, // core clock
	input wire logic i_rst_b, // async reset, low
	smbus_if.host bus, // two-wire bus
	input wire logic i_cmd_valid, // pulse: begin transaction
	input wire logic [6:0] i_cmd_addr, // slave address
	input wire logic i_cmd_read, // one reads, zero writes
	input wire logic [3:0] i_cmd_len, // data bytes, 1 to 15
	input wire logic [7:0] i_wr_data, // next write byte
	output logic o_wr_taken, // pulse: write byte used
	output logic [7:0] o_rd_data, // byte read
	output logic o_rd_valid, // pulse: byte read
	output logic o_nack, // pulse: slave did not ack
	output logic o_busy, // transaction running
	output logic o_scl_oe, // mirror of scl pull-down
	output logic o_sda_oe // mirror of sda pull-down
);
	////////////////////////////////////////////////////////////////
	master_state_t state_reg;
	logic [1:0] scl_sync_reg;
	logic [1:0] sda_sync_reg;
	logic [4:0] tick_reg;
	logic [7:0] shift_reg;
	logic [2:0] bit_reg;
	logic [3:0] left_reg;
	logic addr_phase_reg;
	logic read_reg;
	wire logic scl_s = scl_sync_reg[1];
	wire logic sda_s = sda_sync_reg[1];
	// half bit of 10 clocks keeps rate at core/20; RULE_11
	wire logic tick_done = (tick_reg == 5'(HALF_BIT_CYCLES - 1));
	wire logic sending = addr_phase_reg || !read_reg;
	wire logic last_byte = (left_reg == 4'h1);

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			scl_sync_reg <= 2'h3;
			sda_sync_reg <= 2'h3;
		end else begin
			scl_sync_reg <= {scl_sync_reg[0], bus.scl};
			sda_sync_reg <= {sda_sync_reg[0], bus.sda};
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state_reg <= MS_IDLE;
			tick_reg <= 5'h00;
			shift_reg <= 8'h00;
			bit_reg <= 3'h0;
			left_reg <= 4'h0;
			addr_phase_reg <= 1'b0;
			read_reg <= 1'b0;
			o_scl_oe <= 1'b0;
			o_sda_oe <= 1'b0;
			o_rd_data <= 8'h00;
			o_rd_valid <= 1'b0;
			o_wr_taken <= 1'b0;
			o_nack <= 1'b0;
			o_busy <= 1'b0;
		end else begin
			o_rd_valid <= 1'b0;
			o_wr_taken <= 1'b0;
			o_nack <= 1'b0;
			// a held-low scl freezes the timer: stretch honoured; RULE_09
			if (state_reg == MS_IDLE || tick_done)
				tick_reg <= 5'h00;
			else if (!(o_scl_oe == 1'b0 && !scl_s))
				tick_reg <= tick_reg + 5'h01;
			case (state_reg)
			MS_IDLE: begin
				if (i_cmd_valid && i_cmd_len != 4'h0) begin
					state_reg <= MS_START;
					shift_reg <= {i_cmd_addr, i_cmd_read}; // RULE_03 RULE_04
					read_reg <= i_cmd_read;
					left_reg <= i_cmd_len;
					addr_phase_reg <= 1'b1;
					bit_reg <= 3'h0;
					o_sda_oe <= 1'b1; // RULE_02
					o_busy <= 1'b1;
				end
			end
			MS_START: if (tick_done) begin
				state_reg <= MS_BIT_LOW;
				o_scl_oe <= 1'b1;
			end
			MS_BIT_LOW: if (tick_done) begin
				state_reg <= MS_BIT_HIGH;
				o_scl_oe <= 1'b0;
			end else if (tick_reg == 5'h01) begin
				o_sda_oe <= sending ? ~shift_reg[7] : 1'b0; // RULE_08 RULE_12
			end
			MS_BIT_HIGH: if (tick_done) begin
				shift_reg <= {shift_reg[6:0], sda_s};
				bit_reg <= bit_reg + 3'h1;
				o_scl_oe <= 1'b1;
				state_reg <= (bit_reg == 3'h7) ? MS_ACK_LOW : MS_BIT_LOW;
			end
			MS_ACK_LOW: if (tick_done) begin
				state_reg <= MS_ACK_HIGH;
				o_scl_oe <= 1'b0;
			end else if (tick_reg == 5'h01) begin
				// master acks reads except the last; RULE_05 RULE_07
				o_sda_oe <= !sending && !last_byte;
				if (!sending) begin
					o_rd_data <= shift_reg;
					o_rd_valid <= 1'b1;
				end
			end
			MS_ACK_HIGH: if (tick_done) begin
				o_scl_oe <= 1'b1;
				addr_phase_reg <= 1'b0;
				if (sending && sda_s) begin
					o_nack <= 1'b1; // RULE_05
					state_reg <= MS_STOP_LOW;
				end else if (!addr_phase_reg && last_byte) begin
					state_reg <= MS_STOP_LOW;
				end else begin
					if (!addr_phase_reg)
						left_reg <= left_reg - 4'h1;
					if (!read_reg) begin
						shift_reg <= i_wr_data;
						o_wr_taken <= 1'b1;
					end
					state_reg <= MS_BIT_LOW;
				end
			end
			MS_STOP_LOW: if (tick_done) begin
				state_reg <= MS_STOP_HIGH;
				o_scl_oe <= 1'b0;
			end else if (tick_reg == 5'h01) begin
				o_sda_oe <= 1'b1;
			end
			MS_STOP_HIGH: if (tick_done) begin
				state_reg <= MS_STOP_END;
				o_sda_oe <= 1'b0; // RULE_02
			end
			MS_STOP_END: if (tick_done) begin
				state_reg <= MS_IDLE;
				o_busy <= 1'b0;
			end
			default: state_reg <= MS_IDLE;
			endcase
		end
	end
	assign bus.host_scl_oe = o_scl_oe;
	assign bus.host_sda_oe = o_sda_oe;
endmodule
`default_nettype wire

// File: bench/smbus_link_properties.sv
`timescale 1ns/1ps
`default_nettype none
module smbus_link_properties #(
	parameter int LOW_LIMIT = 200
) (
	input wire logic i_core_clk, // core clock
	input wire logic i_rst_b, // async reset, low
	input wire logic scl, // clock line
	input wire logic sda, // data line
	input wire logic dev_scl_oe, // slave pulls scl
	input wire logic dev_sda_oe, // slave pulls sda
	input wire logic host_scl_oe, // host pulls scl
	input wire logic host_sda_oe // host pulls sda
);
	////////////////////////////////////////////////////////////////
	logic scl_d_reg, sda_d_reg, first_reg, rw_reg, ign_reg;
	logic [3:0] bit_reg;
	int stretch_reg;
	wire logic rise = scl & ~scl_d_reg;
	wire logic start = scl & scl_d_reg & sda_d_reg & ~sda;
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
			stretch_reg <= 0;
		end else begin
			scl_d_reg <= scl;
			sda_d_reg <= sda;
			stretch_reg <= dev_scl_oe ? stretch_reg + 1 : 0;
		end
	end
	// bit position inside the current byte, ack bit is 8
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			bit_reg <= 4'h0;
			first_reg <= 1'b0;
			rw_reg <= 1'b0;
			ign_reg <= 1'b0;
		end else if (start) begin
			bit_reg <= 4'h0;
			first_reg <= 1'b1;
			ign_reg <= 1'b0;
		end else if (rise && bit_reg == 4'h8) begin
			bit_reg <= 4'h0;
			first_reg <= 1'b0;
			ign_reg <= ign_reg | (first_reg & sda);
		end else if (rise) begin
			bit_reg <= bit_reg + 4'h1;
			if (first_reg && bit_reg == 4'h7) rw_reg <= sda;
		end
	end
	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_rst_b);
	a_sda_turn_low: assert property ($changed(dev_sda_oe) |-> !scl)
		else $error("slave sda moved with scl high");
	a_stretch_in_low: assert property ($rose(dev_scl_oe) |-> host_scl_oe)
		else $error("slave began a clock low phase");
	a_stretch_bound: assert property (stretch_reg <= LOW_LIMIT + 8)
		else $error("stretch outlived the timeout");
	a_addr_quiet: assert property ((rise && bit_reg < 4'h8 && (first_reg || !rw_reg)) |-> !dev_sda_oe)
		else $error("slave drove a host data bit");
	a_addr_ack: assert property ((rise && first_reg && bit_reg == 4'h8 && !sda) |-> dev_sda_oe)
		else $error("address ack not from slave");
	a_write_ack: assert property ((rise && !first_reg && !rw_reg && !ign_reg && bit_reg == 4'h8) |-> dev_sda_oe)
		else $error("write byte not acked");
	a_read_ack_host: assert property ((rise && !first_reg && rw_reg && bit_reg == 4'h8) |-> !dev_sda_oe)
		else $error("slave drove the host ack");
	a_nomatch_quiet: assert property (ign_reg |-> !dev_sda_oe && !dev_scl_oe)
		else $error("unaddressed slave drove the bus");
	a_scl_high_len: assert property ($rose(scl) |-> scl [*8])
		else $error("scl high phase too short");
	a_ack_host_free: assert property ((rise && bit_reg == 4'h8 && (first_reg || !rw_reg)) |-> !host_sda_oe)
		else $error("host drove sda in the slave ack bit");
	cover property (rise && first_reg && bit_reg == 4'h8 && !sda);
	cover property (ign_reg);
	cover property (stretch_reg == 100);
endmodule
`default_nettype wire

// File: bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	import smbus_pkg::*;
	localparam int LOW_LIMIT = 200;
	typedef struct packed {logic rd; logic sel; logic miss; logic [3:0] len;} row_t;
	logic i_core_clk, i_rst_b, sel, cmd_valid, cmd_read, tx_valid, busy_seen;
	logic tx_taken, rx_valid, s_busy, timeout, wr_taken, rd_valid, nack, h_busy, h_scl_oe, h_sda_oe;
	logic [6:0] cmd_addr;
	logic [3:0] cmd_len;
	logic [7:0] rx_data, rd_data;
	logic [7:0] buf_b [16];
	logic [7:0] rx_q [$];
	logic [7:0] rd_q [$];
	int wr_idx, tx_idx, err_count, n_tests, to_cnt, nack_cnt;
	row_t rows [6] = '{'{1'b0, 1'b0, 1'b0, 4'h1}, '{1'b0, 1'b1, 1'b0, 4'h3}, '{1'b1, 1'b0, 1'b0, 4'h2},
		'{1'b1, 1'b1, 1'b0, 4'h1}, '{1'b0, 1'b0, 1'b1, 4'h2}, '{1'b1, 1'b1, 1'b1, 4'h1}};
	smbus_if bus();
	smbus_slave_port #(.SCL_LOW_LIMIT(LOW_LIMIT)) u_smbus_slave_port (.i_core_clk(i_core_clk),
		.i_rst_b(i_rst_b), .bus(bus.device), .i_slave_address_select_pin(sel), .i_free_timeout_en(1'b1),
		.i_scl_low_timeout_en(1'b1), .i_tx_data(buf_b[tx_idx[3:0]]), .i_tx_valid(tx_valid),
		.o_tx_taken(tx_taken), .o_rx_data(rx_data), .o_rx_valid(rx_valid), .o_busy(s_busy), .o_timeout(timeout));
	smbus_host_master u_smbus_host_master (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .bus(bus.host),
		.i_cmd_valid(cmd_valid), .i_cmd_addr(cmd_addr), .i_cmd_read(cmd_read), .i_cmd_len(cmd_len),
		.i_wr_data(buf_b[wr_idx[3:0]]), .o_wr_taken(wr_taken), .o_rd_data(rd_data), .o_rd_valid(rd_valid),
		.o_nack(nack), .o_busy(h_busy), .o_scl_oe(h_scl_oe), .o_sda_oe(h_sda_oe));
	smbus_link_properties #(.LOW_LIMIT(LOW_LIMIT)) chk (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
		.scl(bus.scl), .sda(bus.sda), .dev_scl_oe(bus.dev_scl_oe), .dev_sda_oe(bus.dev_sda_oe),
		.host_scl_oe(bus.host_scl_oe), .host_sda_oe(bus.host_sda_oe));
	////////////////////////////////////////////////////////////////
	initial begin
		i_core_clk = 1'b0;
		forever #12.5 i_core_clk = ~i_core_clk;
	end
	always @(posedge i_core_clk) begin
		if (rx_valid) rx_q.push_back(rx_data);
		if (rd_valid) rd_q.push_back(rd_data);
		if (timeout) to_cnt++;
		if (nack) nack_cnt++;
		if (s_busy) busy_seen = 1'b1;
		if (wr_taken) wr_idx <= wr_idx + 1;
		if (tx_taken) tx_idx <= tx_idx + 1;
	end
	////////////////////////////////////////////////////////////////
	task chk_byte(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task chk_bit(input logic got, input logic exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task chk_cnt(input int got, input int exp);
		n_tests++;
		if (got != exp) begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task final_report;
		if (err_count == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// one host transaction; waits for the host to go idle again
	task txn(input row_t r, input int k);
		int w;
		rx_q.delete();
		rd_q.delete();
		wr_idx = 0;
		tx_idx = 0;
		nack_cnt = 0;
		busy_seen = 1'b0;
		for (int i = 0; i < 16; i++) buf_b[i] = 8'(8'h3C + k * 29 + i * 7);
		sel = r.sel;
		cmd_read = r.rd;
		cmd_len = r.len;
		cmd_addr = {SLAVE_ADDR_BASE[6:1], r.sel ^ r.miss};
		@(posedge i_core_clk);
		#2 cmd_valid = 1'b1;
		@(posedge i_core_clk);
		#2 cmd_valid = 1'b0;
		w = 0;
		while (h_busy !== 1'b0 && w < 20000) begin
			@(posedge i_core_clk);
			w++;
		end
		if (w == 20000) err_count++;
		repeat (20) @(posedge i_core_clk);
		#2;
	endtask
	task run_row(input row_t r, input int k);
		txn(r, k);
		chk_bit(busy_seen, 1'b1);
		chk_bit(s_busy, 1'b0);
		chk_bit(h_scl_oe | h_sda_oe, 1'b0);
		chk_bit(bus.scl & bus.sda, 1'b1);
		chk_cnt(nack_cnt, int'(r.miss));
		chk_cnt(r.rd ? rd_q.size() : rx_q.size(), r.miss ? 0 : int'(r.len));
		for (int i = 0; i < int'(r.len) && !r.miss; i++) begin
			chk_byte(r.rd ? rd_q[i] : rx_q[i], buf_b[i]);
		end
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (60000) @(posedge i_core_clk);
		err_count++;
		final_report();
	end
	initial begin
		i_rst_b = 1'b0;
		{sel, cmd_valid, cmd_read, cmd_addr, cmd_len} = '0;
		tx_valid = 1'b1;
		{wr_idx, tx_idx, err_count, n_tests, to_cnt, nack_cnt} = '0;
		for (int i = 0; i < 16; i++) buf_b[i] = 8'h00;
		repeat (5) @(posedge i_core_clk);
		#2;
		chk_bit(bus.scl, 1'b1);
		chk_bit(bus.sda, 1'b1);
		chk_bit(s_busy, 1'b0);
		repeat (5) @(posedge i_core_clk);
		#2 i_rst_b = 1'b1;
		repeat (4) @(posedge i_core_clk);
		#2;
		for (int k = 0; k < 6; k++) run_row(rows[k], k);
		// no byte offered: slave stretches until its own timeout
		tx_valid = 1'b0;
		txn('{1'b1, 1'b0, 1'b0, 4'h1}, 7);
		chk_byte(rd_q[0], 8'hFF);
		tx_valid = 1'b1;
		run_row('{1'b0, 1'b1, 1'b0, 4'hF}, 8);
		chk_cnt(to_cnt, 1);
		final_report();
	end
endmodule
`default_nettype wire
